/* File: rtl/mra_pkg.sv */
// Package for the region attribute check block: map, fields and types
package mra_pkg;
	// ====================================================
	// Register map (byte addresses)
	localparam logic [7:0] ATTR_BASE_OFS = 8'h00;
	localparam logic [7:0] CTRL_OFS      = 8'h20;
	localparam logic [7:0] FSTAT_OFS     = 8'h24;
	localparam logic [7:0] FADDR_OFS     = 8'h28;
	localparam logic [7:0] ISTAT_OFS     = 8'h2c;
	localparam logic [7:0] IMASK_OFS     = 8'h30;
	localparam logic [7:0] RESULT_OFS    = 8'h34;
	localparam int         NUM_REGIONS   = 8;
	localparam int         REGION_W      = 3;
	localparam int         ATTR_W        = 13;
	// ====================================================
	// Attribute register fields
	localparam int BUF_BIT  = 0;
	localparam int CACH_BIT = 1;
	localparam int SHR_BIT  = 2;
	localparam int EXT_LO   = 3;
	localparam int PERM_LO  = 8;
	localparam int XN_BIT   = 12;
	// ====================================================
	// Fault status, interrupt and control bits
	localparam int FS_INSTR_BIT  = 0;
	localparam int FS_DATA_BIT   = 1;
	localparam int FS_AVALID_BIT = 7;
	localparam int FS_W          = 8;
	localparam int IRQ_FAULT_BIT = 0;
	localparam int IRQ_RSVD_BIT  = 1;
	localparam int IRQ_W         = 2;
	localparam int CTRL_EN_BIT   = 0;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	// ====================================================
	// Encodings
	localparam logic [2:0] PERM_NONE    = 3'h0;
	localparam logic [2:0] PERM_PRIV    = 3'h1;
	localparam logic [2:0] PERM_URO     = 3'h2;
	localparam logic [2:0] PERM_FULL    = 3'h3;
	localparam logic [2:0] PERM_RSVD    = 3'h4;
	localparam logic [2:0] PERM_PRO     = 3'h5;
	localparam logic [2:0] EXT_LEGACY   = 3'h0;
	localparam logic [2:0] EXT_NONCACHE = 3'h1;
	localparam logic [2:0] EXT_DEVICE   = 3'h2;
	localparam logic [1:0] POL_NC       = 2'h0;
	localparam logic [1:0] POL_WB_RWA   = 2'h1;
	localparam logic [1:0] POL_WT_NWA   = 2'h2;
	localparam logic [1:0] POL_WB_NWA   = 2'h3;

	typedef enum logic [1:0] {MT_STRONG, MT_DEVICE, MT_NORMAL, MT_RESERVED} mra_mtype_e;

	typedef struct packed {
		logic        valid;
		logic        priv;
		logic        write;
		logic        fetch;
		logic [7:0]  hit;
		logic [31:0] addr;
	} mra_req_s;

	typedef struct packed {
		logic                valid;
		logic                permit;
		logic                fault;
		logic                hit;
		logic [REGION_W-1:0] region;
		mra_mtype_e          mtype;
		logic                shareable;
		logic [1:0]          inner;
		logic [1:0]          outer;
	} mra_res_s;
endpackage

/* File: rtl/mra_check.sv */
// Region attribute decode and permission check with APB register file
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none

module mra_check
(
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire mra_pkg::mra_req_s  acc_req,
	output mra_pkg::mra_res_s       acc_res,
	output logic                    mem_fault,
	output logic                    irq
);
	// ====================================================
	// Region attribute store, control, status and output registers
	logic [mra_pkg::ATTR_W-1:0]  attr_q [mra_pkg::NUM_REGIONS];
	logic                        ctrl_en_q;
	logic [mra_pkg::FS_W-1:0]    fstat_q;
	logic [31:0]                 faddr_q;
	logic [mra_pkg::IRQ_W-1:0]   istat_q;
	logic [mra_pkg::IRQ_W-1:0]   imask_q;
	mra_pkg::mra_res_s           res_q;
	logic                        fault_q;
	logic                        irq_q;
	logic [31:0]                 prdata_q;
	logic                        pready_q;
	logic                        pslverr_q;

	// ====================================================
	// APB decode
	wire         setup_w   = psel & ~penable & ~pready_q;
	wire         commit_w  = psel & penable & pready_q;
	wire         is_attr_w = (paddr[7:5] == mra_pkg::ATTR_BASE_OFS[7:5]) & (paddr[1:0] == 2'h0);
	wire [2:0]   attr_ix_w = paddr[4:2];
	wire         is_ctrl_w = (paddr == mra_pkg::CTRL_OFS);
	wire         is_fst_w  = (paddr == mra_pkg::FSTAT_OFS);
	wire         is_fad_w  = (paddr == mra_pkg::FADDR_OFS);
	wire         is_ist_w  = (paddr == mra_pkg::ISTAT_OFS);
	wire         is_imk_w  = (paddr == mra_pkg::IMASK_OFS);
	wire         is_res_w  = (paddr == mra_pkg::RESULT_OFS);
	wire         mapped_w  = is_attr_w | is_ctrl_w | is_fst_w | is_fad_w | is_ist_w
		| is_imk_w | is_res_w;
	wire         wr_w      = commit_w & pwrite & ~pslverr_q;
	wire         rd_ist_w  = commit_w & ~pwrite & is_ist_w;

	wire [31:0]  attr_rd_w = {{(32 - mra_pkg::ATTR_W){1'b0}}, attr_q[attr_ix_w]};
	wire [31:0]  res_rd_w  = {{(32 - $bits(mra_pkg::mra_res_s)){1'b0}}, res_q};
	wire [31:0]  rd_mux_w  =
		is_attr_w ? attr_rd_w :
		is_ctrl_w ? {31'h0000_0000, ctrl_en_q} :
		is_fst_w  ? {24'h00_0000, fstat_q} :
		is_fad_w  ? faddr_q :
		is_ist_w  ? {30'h0000_0000, istat_q} :
		is_imk_w  ? {30'h0000_0000, imask_q} :
		is_res_w  ? res_rd_w : mra_pkg::RESET_WORD;

	// ====================================================
	// Region priority select
	logic [mra_pkg::REGION_W-1:0] sel_chain [mra_pkg::NUM_REGIONS+1];
	logic                         hit_chain [mra_pkg::NUM_REGIONS+1];
	assign sel_chain[0] = '0;
	assign hit_chain[0] = 1'b0;
	genvar gi;
	generate
		for (gi = 0; gi < mra_pkg::NUM_REGIONS; gi++)
		begin : g_prio
			assign sel_chain[gi+1] = acc_req.hit[gi] ? mra_pkg::REGION_W'(gi) : sel_chain[gi];
			assign hit_chain[gi+1] = acc_req.hit[gi] | hit_chain[gi];
		end
	endgenerate

	wire [mra_pkg::REGION_W-1:0] sel_w  = sel_chain[mra_pkg::NUM_REGIONS];
	wire                         any_w  = hit_chain[mra_pkg::NUM_REGIONS];
	wire [mra_pkg::ATTR_W-1:0]   a_w    = attr_q[sel_w];
	wire [2:0]                   ext_w  = a_w[mra_pkg::EXT_LO +: 3];
	wire [2:0]                   perm_w = a_w[mra_pkg::PERM_LO +: 3];
	wire                         c_w    = a_w[mra_pkg::CACH_BIT];
	wire                         b_w    = a_w[mra_pkg::BUF_BIT];
	wire                         s_w    = a_w[mra_pkg::SHR_BIT];
	wire                         xn_w   = a_w[mra_pkg::XN_BIT];

	// ====================================================
	// Permission check
	logic perm_ok;
	always_comb
	begin
		case (perm_w)
			mra_pkg::PERM_NONE: perm_ok = 1'b0;
			mra_pkg::PERM_PRIV: perm_ok = acc_req.priv;
			mra_pkg::PERM_URO:  perm_ok = acc_req.priv | ~acc_req.write;
			mra_pkg::PERM_FULL: perm_ok = 1'b1;
			// Reserved code treated as fault, the safe choice
			mra_pkg::PERM_RSVD: perm_ok = 1'b0;
			mra_pkg::PERM_PRO:  perm_ok = acc_req.priv & ~acc_req.write;
			default:            perm_ok = ~acc_req.write;
		endcase
	end

	// ====================================================
	// Memory type decode
	mra_pkg::mra_mtype_e mtype;
	logic                share;
	logic [1:0]          inner;
	logic [1:0]          outer;
	always_comb
	begin
		mtype = mra_pkg::MT_RESERVED;
		share = 1'b0;
		inner = mra_pkg::POL_NC;
		outer = mra_pkg::POL_NC;
		if (ext_w[2])
		begin
			// Outer from ext, inner from C and B
			mtype = mra_pkg::MT_NORMAL;
			share = s_w;
			outer = ext_w[1:0];
			inner = {c_w, b_w};
		end
		else
		begin
			case (ext_w)
				mra_pkg::EXT_LEGACY:
				begin
					if (!c_w)
					begin
						mtype = b_w ? mra_pkg::MT_DEVICE : mra_pkg::MT_STRONG;
						share = 1'b1;
					end
					else
					begin
						mtype = mra_pkg::MT_NORMAL;
						share = s_w;
						inner = b_w ? mra_pkg::POL_WB_NWA : mra_pkg::POL_WT_NWA;
						outer = inner;
					end
				end
				mra_pkg::EXT_NONCACHE:
				begin
					if (c_w == b_w)
					begin
						mtype = mra_pkg::MT_NORMAL;
						share = s_w;
						inner = c_w ? mra_pkg::POL_WB_RWA : mra_pkg::POL_NC;
						outer = inner;
					end
				end
				mra_pkg::EXT_DEVICE:
				begin
					if (!c_w && !b_w)
						mtype = mra_pkg::MT_DEVICE;
				end
				default: mtype = mra_pkg::MT_RESERVED;
			endcase
		end
	end

	// ====================================================
	// Access result
	// Privilege and direction arrive with the request
	wire checked_w = acc_req.valid & ctrl_en_q & any_w;
	wire viol_w    = checked_w & (~perm_ok | (acc_req.fetch & xn_w));
	wire rsvd_w    = checked_w & (mtype == mra_pkg::MT_RESERVED);

	mra_pkg::mra_res_s res_d;
	always_comb
	begin
		res_d           = '0;
		res_d.valid     = acc_req.valid;
		res_d.permit    = acc_req.valid & ~viol_w;
		res_d.fault     = viol_w;
		res_d.hit       = checked_w;
		res_d.region    = sel_w;
		res_d.mtype     = checked_w ? mtype : mra_pkg::MT_STRONG;
		// Attributes are reported, never acted on
		res_d.shareable = checked_w & share;
		res_d.inner     = checked_w ? inner : mra_pkg::POL_NC;
		res_d.outer     = checked_w ? outer : mra_pkg::POL_NC;
	end

	// ====================================================
	// Fault status and interrupt next values
	wire [mra_pkg::FS_W-1:0] fs_set_w = viol_w ?
		(mra_pkg::FS_W'(1) << (acc_req.fetch ? mra_pkg::FS_INSTR_BIT : mra_pkg::FS_DATA_BIT))
		| (acc_req.fetch ? '0 : mra_pkg::FS_W'(1) << mra_pkg::FS_AVALID_BIT)
		: '0;
	wire [mra_pkg::FS_W-1:0] fs_clr_w = (wr_w & is_fst_w) ? pwdata[mra_pkg::FS_W-1:0] : '0;
	wire [mra_pkg::FS_W-1:0] fstat_d  = (fstat_q & ~fs_clr_w) | fs_set_w;
	// Address held until software clears its valid bit; a clear in the same cycle frees it
	wire                     fa_load_w = viol_w & ~acc_req.fetch
		& (~fstat_q[mra_pkg::FS_AVALID_BIT] | fs_clr_w[mra_pkg::FS_AVALID_BIT]);

	wire [mra_pkg::IRQ_W-1:0] ev_w    = {rsvd_w, viol_w};
	wire [mra_pkg::IRQ_W-1:0] istat_d = (rd_ist_w ? '0 : istat_q) | ev_w;

	// ====================================================
	// Registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= mra_pkg::RESET_WORD;
		end
		else
		begin
			// No wait state; read data is registered in the setup cycle so it comes from a flop
			pready_q  <= setup_w;
			pslverr_q <= setup_w & ~mapped_w;
			prdata_q  <= (setup_w & ~pwrite) ? rd_mux_w : mra_pkg::RESET_WORD;
		end
	end

	generate
		for (gi = 0; gi < mra_pkg::NUM_REGIONS; gi++)
		begin : g_attr
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					attr_q[gi] <= '0;
				else if (wr_w && is_attr_w && attr_ix_w == 3'(gi))
					attr_q[gi] <= pwdata[mra_pkg::ATTR_W-1:0];
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_en_q <= 1'b0;
			imask_q   <= '0;
		end
		else if (wr_w)
		begin
			ctrl_en_q <= is_ctrl_w ? pwdata[mra_pkg::CTRL_EN_BIT] : ctrl_en_q;
			imask_q   <= is_imk_w ? pwdata[mra_pkg::IRQ_W-1:0] : imask_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fstat_q <= '0;
			faddr_q <= mra_pkg::RESET_WORD;
			istat_q <= '0;
			irq_q   <= 1'b0;
		end
		else
		begin
			fstat_q <= fstat_d;
			faddr_q <= fa_load_w ? acc_req.addr : faddr_q;
			istat_q <= istat_d;
			irq_q   <= |(istat_d & imask_q);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			res_q   <= '0;
			fault_q <= 1'b0;
		end
		else
		begin
			res_q   <= res_d;
			fault_q <= viol_w;
		end
	end

	assign prdata    = prdata_q;
	assign pready    = pready_q;
	assign pslverr   = pslverr_q;
	assign acc_res   = res_q;
	assign mem_fault = fault_q;
	assign irq       = irq_q;
endmodule

`default_nettype wire

/* File: sim/mra_check_asserts.sv */
// Port-level assertions for the region attribute check block
`timescale 1ns/100ps
`default_nettype none
module mra_check_asserts
(
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire mra_pkg::mra_req_s acc_req,
	input wire mra_pkg::mra_res_s acc_res,
	input wire logic              mem_fault,
	input wire logic              irq
);
	// ====================
	// Highest hit index
	logic [2:0] hi_idx;
	always_comb
	begin
		hi_idx = 3'h0;
		for (int j = 0; j < 8; j++)
			if (acc_req.hit[j])
				hi_idx = 3'(j);
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ====================
	// Assertions
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	a_ready_one_shot: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata not zero outside access");
	a_res_follows_req: assert property (acc_req.valid |=> acc_res.valid)
		else $error("result missing after request");
	a_res_no_req: assert property (!acc_req.valid |=> !acc_res.valid)
		else $error("result without request");
	a_fault_pulse: assert property (mem_fault == (acc_res.valid && acc_res.fault))
		else $error("fault pulse not matching result");
	a_permit_excl: assert property (acc_res.valid |-> acc_res.permit != acc_res.fault)
		else $error("permit and fault not exclusive");
	a_region_top: assert property (acc_res.hit |-> acc_res.region == $past(hi_idx))
		else $error("region not highest hit");
	a_nohit_permit: assert property (acc_req.valid && acc_req.hit == 8'h00 |=>
		acc_res.permit && !acc_res.hit && acc_res.mtype == mra_pkg::MT_STRONG)
		else $error("miss not permitted");
	c_fault: cover property (mem_fault);
	c_slverr: cover property (pslverr);
	c_irq: cover property ($rose(irq));
	c_top: cover property (acc_res.hit && acc_res.region == 3'h7);
endmodule
bind mra_check mra_check_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.acc_req(acc_req), .acc_res(acc_res), .mem_fault(mem_fault), .irq(irq));
`default_nettype wire

/* File: sim/mra_core_model.sv */
// Behavioural processor core issuing protected accesses
`timescale 1ns/100ps
`default_nettype none
module mra_core_model
(
	input  wire logic              pclk,
	output var  mra_pkg::mra_req_s acc_req
);
	// ====================
	// Request issue
	initial acc_req = '0;
	task automatic issue(input logic pv, input logic wr, input logic [7:0] h,
		input logic [31:0] a);
		@(posedge pclk);
		acc_req <= '{valid: 1'b1, priv: pv, write: wr, fetch: 1'b0, hit: h, addr: a};
		@(posedge pclk);
		// Stale fields flip so a released request never repeats
		acc_req <= {1'b0, ~acc_req[42:0]};
	endtask
	task automatic fetch_op(input logic pv, input logic [7:0] h, input logic [31:0] a);
		@(posedge pclk);
		acc_req <= '{valid: 1'b1, priv: pv, write: 1'b0, fetch: 1'b1, hit: h, addr: a};
		@(posedge pclk);
		acc_req <= {1'b0, ~acc_req[42:0]};
	endtask
endmodule
`default_nettype wire

/* File: sim/mra_check_tb.sv */
// Self-checking bench for the region attribute check block
`timescale 1ns/100ps
`default_nettype none
module mra_check_tb;
	logic              pclk;
	logic              presetn;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [7:0]        paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	mra_pkg::mra_req_s acc_req;
	mra_pkg::mra_res_s acc_res;
	logic              mem_fault;
	logic              irq;
	logic [12:0]       attr_q [8];
	logic [7:0]        ofs [5];
	logic [12:0]       rec [4];
	logic              ctrl_en;
	logic [31:0]       rd;
	logic              er;
	logic [31:0]       la;
	int                seed;
	int                n_errors;
	int                compares;

	mra_check dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .acc_req(acc_req), .acc_res(acc_res), .mem_fault(mem_fault),
		.irq(irq));
	mra_core_model core (.pclk(pclk), .acc_req(acc_req));

	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// ====================
	// Compare and report
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("Compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ====================
	// Bus and access tasks
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 16)
		begin
			n_errors++;
			tally_and_finish();
		end
	endtask
	task automatic wattr(input int r, input logic [12:0] v);
		apb(1'b1, mra_pkg::ATTR_BASE_OFS + 8'(4 * r), {19'h0, v});
		attr_q[r] = v;
	endtask
	function automatic logic perm_ok(input logic [2:0] p, input logic pv, input logic wr);
		case (p)
			3'h0, 3'h4: return 1'b0;
			3'h1: return pv;
			3'h2: return pv || !wr;
			3'h3: return 1'b1;
			3'h5: return pv && !wr;
			default: return !wr;
		endcase
	endfunction
	function automatic logic [6:0] dec(input logic [12:0] a);
		if (a[5])
			return {2'h2, a[2], a[1:0], a[4:3]};
		if (a[5:3] == 3'h0)
			return a[1] ? {2'h2, a[2], a[0] ? 4'hf : 4'ha} : {1'b0, a[0], 5'h10};
		if (a[5:3] == 3'h1 && a[1] == a[0])
			return {2'h2, a[2], a[1] ? 4'h5 : 4'h0};
		if (a[5:3] == 3'h2 && a[1:0] == 2'h0)
			return 7'h20;
		return 7'h60;
	endfunction
	task automatic acc(input logic pv, input logic wr, input logic [7:0] h);
		logic [6:0] d;
		logic       ok;
		logic       en;
		int         r;
		la = $random(seed);
		core.issue(pv, wr, h, la);
		@(negedge pclk);
		r = 0;
		for (int j = 0; j < 8; j++)
			if (h[j])
				r = j;
		en = ctrl_en && h != 8'h00;
		d = en ? dec(attr_q[r]) : 7'h0;
		ok = en ? perm_ok(attr_q[r][10:8], pv, wr) : 1'b1;
		chk("permit", 32'(acc_res.permit), 32'(ok));
		chk("fault", 32'(mem_fault), 32'(!ok));
		chk("hit", 32'(acc_res.hit), 32'(en));
		if (en)
			chk("region", 32'(acc_res.region), 32'(r));
		chk("mtype", 32'(acc_res.mtype), 32'(d[6:5]));
		if (en && d[6:5] != 2'h3)
			chk("share", 32'(acc_res.shareable), 32'(d[4]));
		if (d[6:5] == 2'h2)
			chk("policy", 32'({acc_res.inner, acc_res.outer}), 32'(d[3:0]));
	endtask
	// ====================
	// Main sequence
	initial
	begin
		seed = 99;
		n_errors = 0;
		compares = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		ctrl_en = 1'b0;
		foreach (attr_q[k])
			attr_q[k] = 13'h0;
		ofs = '{mra_pkg::ATTR_BASE_OFS, mra_pkg::CTRL_OFS, mra_pkg::FSTAT_OFS,
			mra_pkg::ISTAT_OFS, mra_pkg::IMASK_OFS};
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		foreach (ofs[k])
		begin
			apb(1'b0, ofs[k], 32'h0);
			chk("reset value", rd, 32'h0);
		end
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped err", 32'(er), 32'h1);
		acc(1'b0, 1'b1, 8'hff);
		$display("Test reset, map and disabled done");
		apb(1'b1, mra_pkg::CTRL_OFS, 32'h1);
		ctrl_en = 1'b1;
		// Recommended settings lie within the sweep
		for (int t = 0; t < 64; t++)
		begin
			wattr(7, {2'h0, 3'(t) ^ 3'(t >> 3), 2'h0, 6'(t)});
			for (int m = 0; m < 4; m++)
				acc(m[1], m[0], 8'h80);
		end
		acc(1'b1, 1'b0, 8'h00);
		$display("Test encoding sweep done");
		for (int n = 0; n < 96; n++)
		begin
			wattr(n % 8, 13'($random(seed)) & 13'h0fff);
			acc(1'($random(seed)), 1'($random(seed)), 8'($random(seed)));
		end
		$display("Test random overlap done");
		apb(1'b1, mra_pkg::IMASK_OFS, 32'h1);
		apb(1'b1, mra_pkg::FSTAT_OFS, 32'hff);
		apb(1'b0, mra_pkg::ISTAT_OFS, 32'h0);
		wattr(7, 13'h0);
		acc(1'b1, 1'b0, 8'h80);
		chk("irq set", 32'(irq), 32'h1);
		apb(1'b0, mra_pkg::FSTAT_OFS, 32'h0);
		chk("fault status", rd, 32'h82);
		apb(1'b0, mra_pkg::FADDR_OFS, 32'h0);
		chk("fault address", rd, la);
		apb(1'b0, mra_pkg::ISTAT_OFS, 32'h0);
		chk("int status", rd, 32'h1);
		@(negedge pclk);
		chk("irq cleared", 32'(irq), 32'h0);
		apb(1'b1, mra_pkg::IMASK_OFS, 32'h0);
		acc(1'b0, 1'b1, 8'h80);
		chk("irq masked", 32'(irq), 32'h0);
		apb(1'b0, mra_pkg::ISTAT_OFS, 32'h0);
		chk("masked status", rd, 32'h1);
		$display("Test fault record and interrupt done");
		apb(1'b1, mra_pkg::FSTAT_OFS, 32'hff);
		wattr(7, 13'h1300);
		core.fetch_op(1'b1, 8'h80, 32'h0000_1000);
		@(negedge pclk);
		chk("xn fault", 32'(mem_fault), 32'h1);
		chk("xn permit", 32'(acc_res.permit), 32'h0);
		apb(1'b0, mra_pkg::FSTAT_OFS, 32'h0);
		chk("fetch status", rd, 32'h1);
		apb(1'b0, mra_pkg::ISTAT_OFS, 32'h0);
		wattr(7, 13'h0318);
		acc(1'b1, 1'b0, 8'h80);
		apb(1'b0, mra_pkg::ISTAT_OFS, 32'h0);
		chk("reserved status", rd, 32'h2);
		rec = '{13'h0302, 13'h0306, 13'h0307, 13'h0305};
		foreach (rec[k])
		begin
			wattr(3, rec[k]);
			acc(1'b0, 1'b0, 8'h08);
		end
		$display("Test execute-never, reserved and recommended done");
		tally_and_finish();
	end
	initial
	begin
		repeat (90000) @(posedge pclk);
		n_errors++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
